//--- rtl/rtc_flag_consts.svh
`ifndef RTC_FLAG_CONSTS_SVH
`define RTC_FLAG_CONSTS_SVH
// register offsets within the clock map
`define OFS_FLAGS 15'h7FF0
`define OFS_CENT 15'h7FF1
`define OFS_ASEC 15'h7FF2
`define OFS_AMIN 15'h7FF3
`define OFS_AHOUR 15'h7FF4
`define OFS_ADATE 15'h7FF5
`define OFS_IRQCFG 15'h7FF6
`define OFS_WDOG 15'h7FF7
// watchdog_control fields
`define WD_KICK_BIT 7
`define WD_LOCK_BIT 6
// irq_pin_config fields
`define IC_DOG_BIT 7
`define IC_MATCH_BIT 6
`define IC_LOSS_BIT 5
`define IC_BACKUP_BIT 4
`define IC_HIGH_BIT 3
`define IC_PULSE_BIT 2
`define IC_WMASK 8'hFC
// flags fields
`define FL_DOG_BIT 7
`define FL_MATCH_BIT 6
`define FL_LOSS_BIT 5
`define FL_XTAL_BIT 4
`define FL_CAL_BIT 2
`define FL_WHOLD_BIT 1
`define FL_RHOLD_BIT 0
// alarm mask bit position
`define AL_MASK_BIT 7
// timing: 50 MHz system clock
`define CLK_HZ 50000000
`define TICK32_DIV (`CLK_HZ / 32)
`define TICK1K_DIV (`CLK_HZ / 1024)
`define PULSE_MS 200
`define PULSE_TICKS (`PULSE_MS * 32 / 1000)
`define RST_BYTE 8'h00
`endif

//--- rtl/rtc_flag_pkg.sv
package rtc_flag_pkg;
   // interrupt pin output mode
   typedef enum logic [1:0] {
      IRQ_IDLE_ST = 2'b00,
      IRQ_PULSE_ST = 2'b01,
      IRQ_LEVEL_ST = 2'b10
   } irq_state_type;
endpackage

//--- rtl/rtc_tick_if.sv
`timescale 1ns/100ps
// slow time-base enables shared by the divider and the core
interface rtc_tick_if;
   logic tick32; // one-cycle pulse at 32 Hz
   logic tick1k; // one-cycle pulse at 1024 Hz (512 Hz square wave toggles)
   modport src (output tick32, output tick1k);
   modport dst (input tick32, input tick1k);
endinterface

//--- rtl/rtc_tick_div.sv
`timescale 1ns/100ps
`include "rtc_flag_consts.svh"
// divides the system clock into 32 Hz and 1024 Hz enables
module rtc_tick_div #(
   parameter int DIV32 = `TICK32_DIV,
   parameter int DIV1K = `TICK1K_DIV
) (
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // sync reset, high
   rtc_tick_if.src ticks // enable outputs
);
   logic [31:0] cnt32_ff, nxt_cnt32; // 32 Hz divider
   logic [31:0] cnt1k_ff, nxt_cnt1k; // 1024 Hz divider
   logic t32_ff, nxt_t32;
   logic t1k_ff, nxt_t1k;

   // next-state of both dividers
   always_comb begin
      nxt_t32 = (cnt32_ff == 32'(DIV32 - 1));
      nxt_cnt32 = nxt_t32 ? 32'h0 : cnt32_ff + 32'h1;
      nxt_t1k = (cnt1k_ff == 32'(DIV1K - 1));
      nxt_cnt1k = nxt_t1k ? 32'h0 : cnt1k_ff + 32'h1;
   end

   // register the dividers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt32_ff <= 32'h0;
         cnt1k_ff <= 32'h0;
         t32_ff <= 1'b0;
         t1k_ff <= 1'b0;
      end else begin
         cnt32_ff <= nxt_cnt32;
         cnt1k_ff <= nxt_cnt1k;
         t32_ff <= nxt_t32;
         t1k_ff <= nxt_t1k;
      end
   end

   assign ticks.tick32 = t32_ff;
   assign ticks.tick1k = t1k_ff;
endmodule

//--- rtl/rtc_watchdog_alarm_flags.sv
// Function
// - kick reloads watchdog from time-out field
// - kick bit self-clears after reload
// - kick bit always reads zero
// - write lock protects six-bit time-out field
// - set dog, match, supply-loss flags on events
// - supply-loss enable gates pin, flag always
// - polarity: high push-pull or low open-drain
// - pulse about 200 ms or level till read
// - alarm fields: BCD value plus mask bit
// - reading flags clears three event flags
// - flags reset to zero except crystal fail
// - calibration bit outputs 512 Hz square wave
// - calibration bit resets to zero
`timescale 1ns/100ps
`include "rtc_flag_consts.svh"
module rtc_watchdog_alarm_flags
   import rtc_flag_pkg::*;
#(
   parameter int DIV32 = `TICK32_DIV, // system cycles per 1/32 s
   parameter int DIV1K = `TICK1K_DIV, // system cycles per 1/1024 s
   parameter logic [4:0] PULSE_TICKS = 5'(`PULSE_TICKS) // pulse length in 1/32 s
) (
   input wire logic clk_sys, // system clock 50 MHz
   input wire logic sys_rst, // power-up reset, sync, high
   input wire logic busSel, // register select strobe, one cycle
   input wire logic busWr, // 1 write, 0 read
   input wire logic [14:0] busAddr, // byte address
   input wire logic [7:0] busWrData, // write data
   output logic [7:0] busRdData, // read data, valid cycle after select
   input wire logic [7:0] curSec, // running clock seconds, BCD
   input wire logic [7:0] curMin, // running clock minutes, BCD
   input wire logic [7:0] curHour, // running clock hours, BCD
   input wire logic [7:0] curDate, // running clock date, BCD
   input wire logic supplyFail, // power monitor failure level
   input wire logic crystalFail, // oscillator-fail detect pulse
   output logic clockHold, // freeze clock register updates
   output logic clockLoad, // one-cycle: load written clock values
   output logic irqOut, // interrupt pin output value
   output logic irqOe // interrupt pin output enable
);
   // ************************************************************
   // storage and time base
   // ************************************************************
   rtc_tick_if ticks(); // slow enables
   logic [7:0] alarmReg_ff [4]; // sec, min, hour, date match regs
   logic [7:0] nxt_alarmReg [4];
   logic [7:0] cent_ff, nxt_cent; // century count
   logic [7:0] cfg_ff, nxt_cfg; // irq_pin_config
   logic wdLock_ff, nxt_wdLock; // timeout_write_lock
   logic [5:0] wdTime_ff, nxt_wdTime; // timeout_count_field
   logic [5:0] wdCnt_ff, nxt_wdCnt; // running countdown
   logic wdKick_ff, nxt_wdKick; // pending kick
   logic [7:0] flags_ff, nxt_flags; // event_flag_bits
   logic [7:0] rd_ff, nxt_rd; // read data register
   logic matchPrev_ff, nxt_matchPrev; // previous match state
   logic lossPrev_ff, nxt_lossPrev; // previous supply level
   logic [4:0] pulseCnt_ff, nxt_pulseCnt; // pulse timer
   irq_state_type irqSt_ff, nxt_irqSt; // pin mode
   logic sq_ff, nxt_sq; // 512 Hz square wave
   logic irqOut_ff, nxt_irqOut;
   logic irqOe_ff, nxt_irqOe;
   logic hold_ff, nxt_hold;
   logic load_ff, nxt_load;
   logic wr, rdFlags, dogEvt, matchEvt, lossEvt, anyIrq, matchNow;

   rtc_tick_div #(.DIV32(DIV32), .DIV1K(DIV1K)) u_div (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .ticks(ticks)
   );

   // true when a field is masked or equal
   function automatic logic fieldOk(input logic [7:0] al, input logic [7:0] cur);
      fieldOk = al[`AL_MASK_BIT] || (al[6:0] == cur[6:0]);
   endfunction

   // ************************************************************
   // events
   // ************************************************************
   always_comb begin
      wr = busSel && busWr;
      rdFlags = busSel && !busWr && (busAddr == `OFS_FLAGS);
      matchNow = fieldOk(alarmReg_ff[0], curSec) && fieldOk(alarmReg_ff[1], curMin)
         && fieldOk(alarmReg_ff[2], curHour) && fieldOk(alarmReg_ff[3], curDate);
      // edge only, so one match second yields one event
      matchEvt = matchNow && !matchPrev_ff;
      lossEvt = supplyFail && !lossPrev_ff;
      // expiry: countdown reaches zero without a kick; zero field disables
      dogEvt = ticks.tick32 && (wdTime_ff != 6'h0) && !wdKick_ff
         && (wdCnt_ff == 6'h1);
      anyIrq = (dogEvt && cfg_ff[`IC_DOG_BIT]) || (matchEvt && cfg_ff[`IC_MATCH_BIT])
         || (lossEvt && cfg_ff[`IC_LOSS_BIT]);
   end

   // ************************************************************
   // register file next state
   // ************************************************************
   always_comb begin
      nxt_alarmReg = alarmReg_ff;
      nxt_cent = cent_ff;
      nxt_cfg = cfg_ff;
      nxt_wdLock = wdLock_ff;
      nxt_wdTime = wdTime_ff;
      nxt_wdKick = 1'b0;
      nxt_flags = flags_ff;
      nxt_rd = rd_ff;
      nxt_matchPrev = matchNow;
      nxt_lossPrev = supplyFail;
      nxt_load = 1'b0;
      // host writes
      if (wr) begin
         unique case (busAddr)
            `OFS_CENT: nxt_cent = busWrData;
            `OFS_ASEC: nxt_alarmReg[0] = busWrData;
            `OFS_AMIN: nxt_alarmReg[1] = busWrData;
            `OFS_AHOUR: nxt_alarmReg[2] = busWrData;
            `OFS_ADATE: nxt_alarmReg[3] = busWrData;
            `OFS_IRQCFG: nxt_cfg = busWrData & `IC_WMASK;
            `OFS_WDOG: begin
               nxt_wdLock = busWrData[`WD_LOCK_BIT];
               // lock as it stood before this write guards the field
               if (!wdLock_ff) begin
                  nxt_wdTime = busWrData[5:0];
               end
               nxt_wdKick = busWrData[`WD_KICK_BIT];
            end
            `OFS_FLAGS: begin
               nxt_flags[`FL_CAL_BIT] = busWrData[`FL_CAL_BIT];
               nxt_flags[`FL_WHOLD_BIT] = busWrData[`FL_WHOLD_BIT];
               nxt_flags[`FL_RHOLD_BIT] = busWrData[`FL_RHOLD_BIT];
               if (!busWrData[`FL_XTAL_BIT]) begin
                  nxt_flags[`FL_XTAL_BIT] = 1'b0;
               end
               // release of write-hold moves written time into the clock
               nxt_load = flags_ff[`FL_WHOLD_BIT] && !busWrData[`FL_WHOLD_BIT];
            end
            default: ;
         endcase
      end
      // reads; kick position always reads as zero
      if (busSel && !busWr) begin
         unique case (busAddr)
            `OFS_FLAGS: nxt_rd = flags_ff;
            `OFS_CENT: nxt_rd = cent_ff;
            `OFS_ASEC: nxt_rd = alarmReg_ff[0];
            `OFS_AMIN: nxt_rd = alarmReg_ff[1];
            `OFS_AHOUR: nxt_rd = alarmReg_ff[2];
            `OFS_ADATE: nxt_rd = alarmReg_ff[3];
            `OFS_IRQCFG: nxt_rd = cfg_ff;
            `OFS_WDOG: nxt_rd = {1'b0, wdLock_ff, wdTime_ff};
            default: nxt_rd = 8'h00;
         endcase
      end
      // read clears event flags; new events win over the clear
      if (rdFlags) begin
         nxt_flags[`FL_DOG_BIT] = 1'b0;
         nxt_flags[`FL_MATCH_BIT] = 1'b0;
         nxt_flags[`FL_LOSS_BIT] = 1'b0;
      end
      if (dogEvt) nxt_flags[`FL_DOG_BIT] = 1'b1;
      if (matchEvt) nxt_flags[`FL_MATCH_BIT] = 1'b1;
      if (lossEvt) nxt_flags[`FL_LOSS_BIT] = 1'b1;
      if (crystalFail) nxt_flags[`FL_XTAL_BIT] = 1'b1;
      nxt_flags[3] = 1'b0;
      nxt_hold = nxt_flags[`FL_WHOLD_BIT];
   end

   // ************************************************************
   // watchdog countdown
   // ************************************************************
   always_comb begin
      nxt_wdCnt = wdCnt_ff;
      // an idle counter picks up a newly written time-out at once,
      // otherwise it would wrap and run the full six-bit range first
      if (wdKick_ff || wdTime_ff == 6'h0 || wdCnt_ff == 6'h0) begin
         nxt_wdCnt = wdTime_ff;
      end else if (ticks.tick32) begin
         nxt_wdCnt = (wdCnt_ff == 6'h1) ? wdTime_ff : wdCnt_ff - 6'h1;
      end
   end

   // ************************************************************
   // interrupt pin
   // ************************************************************
   always_comb begin
      logic act;
      act = 1'b0;
      nxt_irqSt = irqSt_ff;
      nxt_pulseCnt = pulseCnt_ff;
      nxt_sq = ticks.tick1k ? !sq_ff : sq_ff;
      unique case (irqSt_ff)
         IRQ_IDLE_ST: begin
            if (anyIrq) begin
               nxt_irqSt = cfg_ff[`IC_PULSE_BIT] ? IRQ_PULSE_ST : IRQ_LEVEL_ST;
               nxt_pulseCnt = PULSE_TICKS;
            end
         end
         IRQ_PULSE_ST: begin
            if (ticks.tick32) begin
               nxt_pulseCnt = pulseCnt_ff - 5'h1;
               if (pulseCnt_ff == 5'h1) nxt_irqSt = IRQ_IDLE_ST;
            end
         end
         IRQ_LEVEL_ST: begin
            if (rdFlags) nxt_irqSt = IRQ_IDLE_ST;
         end
         default: nxt_irqSt = IRQ_IDLE_ST;
      endcase
      act = (irqSt_ff != IRQ_IDLE_ST);
      if (flags_ff[`FL_CAL_BIT]) begin
         // square wave replaces interrupts while calibrating
         act = sq_ff;
      end
      if (cfg_ff[`IC_HIGH_BIT]) begin
         nxt_irqOut = act;
         nxt_irqOe = 1'b1;
      end else begin
         nxt_irqOut = 1'b0;
         nxt_irqOe = act;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) alarmReg_ff[i] <= `RST_BYTE;
         cent_ff <= `RST_BYTE;
         cfg_ff <= `RST_BYTE;
         wdLock_ff <= 1'b0;
         wdTime_ff <= 6'h00;
         wdCnt_ff <= 6'h00;
         wdKick_ff <= 1'b0;
         // crystal fail keeps its own state across power-up
         flags_ff <= `RST_BYTE | (flags_ff & (8'h01 << `FL_XTAL_BIT));
         rd_ff <= `RST_BYTE;
         matchPrev_ff <= 1'b1;
         lossPrev_ff <= 1'b0;
         pulseCnt_ff <= 5'h00;
         irqSt_ff <= IRQ_IDLE_ST;
         sq_ff <= 1'b0;
         irqOut_ff <= 1'b0;
         irqOe_ff <= 1'b0;
         hold_ff <= 1'b0;
         load_ff <= 1'b0;
      end else begin
         alarmReg_ff <= nxt_alarmReg;
         cent_ff <= nxt_cent;
         cfg_ff <= nxt_cfg;
         wdLock_ff <= nxt_wdLock;
         wdTime_ff <= nxt_wdTime;
         wdCnt_ff <= nxt_wdCnt;
         wdKick_ff <= nxt_wdKick;
         flags_ff <= nxt_flags;
         rd_ff <= nxt_rd;
         matchPrev_ff <= nxt_matchPrev;
         lossPrev_ff <= nxt_lossPrev;
         pulseCnt_ff <= nxt_pulseCnt;
         irqSt_ff <= nxt_irqSt;
         sq_ff <= nxt_sq;
         irqOut_ff <= nxt_irqOut;
         irqOe_ff <= nxt_irqOe;
         hold_ff <= nxt_hold;
         load_ff <= nxt_load;
      end
   end

   assign busRdData = rd_ff;
   assign clockHold = hold_ff;
   assign clockLoad = load_ff;
   assign irqOut = irqOut_ff;
   assign irqOe = irqOe_ff;

   // ************************************************************
   // checks
   // ************************************************************
   a_kick_reads_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      busSel && !busWr && busAddr == `OFS_WDOG |=> !busRdData[`WD_KICK_BIT])
      else $error("kick bit read as one");
   a_kick_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wdKick_ff |=> wdCnt_ff == $past(wdTime_ff))
      else $error("kick did not reload counter");
   a_kick_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wdKick_ff && !(wr && busAddr == `OFS_WDOG) |=> !wdKick_ff)
      else $error("kick did not self clear");
   a_lock_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wdLock_ff && wr && busAddr == `OFS_WDOG |=> $stable(wdTime_ff))
      else $error("locked time-out changed");
   a_zero_no_dog: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wdTime_ff == 6'h0 |=> !$rose(flags_ff[`FL_DOG_BIT]))
      else $error("disabled watchdog expired");
   a_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      dogEvt |=> flags_ff[`FL_DOG_BIT])
      else $error("dog flag not set");
   a_read_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
      rdFlags && !matchEvt |=> !flags_ff[`FL_MATCH_BIT])
      else $error("match flag survived read");
   a_loss_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
      irqSt_ff == IRQ_IDLE_ST && lossEvt && cfg_ff[`IC_LOSS_BIT] |=> irqSt_ff != IRQ_IDLE_ST)
      else $error("supply loss did not raise pin");
   a_opendrain_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !$past(cfg_ff[`IC_HIGH_BIT]) |-> !irqOut)
      else $error("open drain drove high");
   a_level_till_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
      irqSt_ff == IRQ_LEVEL_ST && !rdFlags |=> irqSt_ff == IRQ_LEVEL_ST)
      else $error("level dropped without read");
endmodule

//--- verif/host_bus_model.sv
`timescale 1ns/100ps
// ****************************************
// host processor side of the byte bus
// ****************************************
module host_bus_model (
   input wire logic clk_sys, // system clock
   output logic busSel, // access strobe
   output logic busWr, // 1 write, 0 read
   output logic [14:0] busAddr, // byte address
   output logic [7:0] busWrData, // write data
   input wire logic [7:0] busRdData // read data
);
   // idle bus at time zero
   initial begin
      busSel = 1'b0;
      busWr = 1'b0;
      busAddr = 15'h0000;
      busWrData = 8'hA5;
   end

   // one access: select held for exactly one sampling edge
   // the host clears crystal fail and write hold by writing zero here
   task automatic acc(input logic wr, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk_sys);
      #2;
      busSel = 1'b1;
      busWr = wr;
      busAddr = a;
      busWrData = d;
      @(posedge clk_sys);
      #2;
      busSel = 1'b0;
      // released data lines must not keep the old value
      busWrData = ~d;
      q = busRdData;
   endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
`include "rtc_flag_consts.svh"
module tb;
   localparam int D32 = 8; // short 1/32 s tick so timers finish fast
   localparam int D1K = 2; // short 1/1024 s tick
   localparam logic [4:0] PT = 5'h06; // pulse length in ticks
   logic clk_sys = 1'b0; // system clock
   logic sys_rst = 1'b1; // reset, high
   logic busSel; // from host model
   logic busWr;
   logic [14:0] busAddr;
   logic [7:0] busWrData;
   logic [7:0] busRdData;
   logic [7:0] curSec = 8'h00; // running clock stand-ins
   logic [7:0] curMin = 8'h00;
   logic [7:0] curHour = 8'h00;
   logic [7:0] curDate = 8'h00;
   logic supplyFail = 1'b0; // power monitor
   logic crystalFail = 1'b0; // oscillator monitor
   logic clockHold;
   logic clockLoad;
   logic irqOut;
   logic irqOe;
   logic hiMode = 1'b0; // bench copy of polarity bit
   logic [7:0] rd; // last read byte
   int err_count = 0;
   int total_checks = 0;
   wire intPin = irqOe ? irqOut : 1'b1; // pull-up holds open-drain pin high
   logic [8:0] srcTbl [7] = '{9'h048, 9'h040, 9'h04C, 9'h008, 9'h128, 9'h108, 9'h124};

   always #10 clk_sys = ~clk_sys;

   rtc_watchdog_alarm_flags #(.DIV32(D32), .DIV1K(D1K), .PULSE_TICKS(PT)) u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .busSel(busSel), .busWr(busWr),
      .busAddr(busAddr), .busWrData(busWrData), .busRdData(busRdData),
      .curSec(curSec), .curMin(curMin), .curHour(curHour), .curDate(curDate),
      .supplyFail(supplyFail), .crystalFail(crystalFail), .clockHold(clockHold),
      .clockLoad(clockLoad), .irqOut(irqOut), .irqOe(irqOe));

   host_bus_model u_host (
      .clk_sys(clk_sys), .busSel(busSel), .busWr(busWr), .busAddr(busAddr),
      .busWrData(busWrData), .busRdData(busRdData));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [7:0] toBcd(input int v);
      return 8'(((v / 10) << 4) | (v % 10));
   endfunction

   // pin is active when it sits at the level chosen by polarity
   function automatic logic pinAct();
      return hiMode ? intPin : ~intPin;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      u_host.acc(1'b1, a, d, rd);
   endtask

   task automatic rdm(input logic [14:0] a, input logic [7:0] m, input logic [7:0] e);
      u_host.acc(1'b0, a, 8'h00, rd);
      chk(rd & m, e);
   endtask

   task automatic pinChk(input logic e);
      chk({7'h00, pinAct()}, {7'h00, e});
   endtask

   // bounded wait for the pin to reach a state
   task automatic waitPin(input logic e);
      int n;
      n = 0;
      while (pinAct() !== e && n < 30) begin
         cyc(1);
         n++;
      end
      pinChk(e);
   endtask

   // one interrupt source under one pin setup; bit 8 picks supply loss
   task automatic srcTest(input logic [8:0] t);
      logic en;
      logic [7:0] fl;
      en = t[8] ? t[5] : t[6];
      fl = t[8] ? 8'h20 : 8'h40;
      wr(`OFS_IRQCFG, t[7:0]);
      hiMode = t[3];
      u_host.acc(1'b0, `OFS_FLAGS, 8'h00, rd);
      cyc(3);
      pinChk(1'b0);
      if (t[8]) supplyFail = 1'b1;
      else curSec = 8'h25;
      if (en) waitPin(1'b1);
      else begin
         cyc(20);
         pinChk(1'b0);
      end
      // pulse mode: still active late in the pulse, gone after it
      if (en && t[2]) begin
         cyc((PT - 1) * D32 - 4);
         pinChk(1'b1);
         cyc(2 * D32 + 4);
         pinChk(1'b0);
      end
      rdm(`OFS_FLAGS, 8'hE0, fl);
      cyc(3);
      pinChk(1'b0);
      rdm(`OFS_FLAGS, 8'hE0, 8'h00);
      supplyFail = 1'b0;
      curSec = 8'h00;
      cyc(2);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      finish_test();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int cnt;
      logic [7:0] v;
      logic [14:0] a;
      logic p;
      void'($urandom(51566));
      repeat (3) @(posedge clk_sys);
      #2;
      sys_rst = 1'b0;
      rdm(`OFS_FLAGS, 8'hEF, 8'h00);
      rdm(`OFS_IRQCFG, 8'hFF, 8'h00);
      rdm(`OFS_WDOG, 8'hFF, 8'h00);
      rdm(15'h1234, 8'hFF, 8'h00);
      $display("test reset done");
      // random compare values and masks, read back whole
      for (int i = 0; i < 12; i++) begin
         a = `OFS_CENT + 15'($urandom_range(4));
         v = toBcd($urandom_range(23));
         if (a != `OFS_CENT) v[7] = 1'($urandom_range(1));
         wr(a, v);
         rdm(a, 8'hFF, v);
         v = 8'($urandom);
         wr(`OFS_IRQCFG, v);
         rdm(`OFS_IRQCFG, 8'hFF, v & `IC_WMASK);
      end
      wr(`OFS_IRQCFG, 8'h00);
      wr(`OFS_ASEC, 8'h25);
      wr(`OFS_AMIN, 8'h80);
      wr(`OFS_AHOUR, 8'h80);
      wr(`OFS_ADATE, 8'h80);
      // a pulse started by the random setup must run out before the pin checks
      cyc(PT * D32 + D32);
      $display("test regs done");
      for (int i = 0; i < 7; i++) srcTest(srcTbl[i]);
      // an unmasked minute must also match
      wr(`OFS_AMIN, 8'h10);
      curSec = 8'h25;
      cyc(5);
      rdm(`OFS_FLAGS, 8'h40, 8'h00);
      curSec = 8'h00;
      curMin = 8'h10;
      cyc(2);
      curSec = 8'h25;
      cyc(5);
      rdm(`OFS_FLAGS, 8'h40, 8'h40);
      wr(`OFS_AMIN, 8'h80);
      $display("test alarm done");
      wr(`OFS_WDOG, 8'h83);
      rdm(`OFS_WDOG, 8'hFF, 8'h03);
      u_host.acc(1'b0, `OFS_FLAGS, 8'h00, rd);
      repeat (6) begin
         cyc(D32);
         wr(`OFS_WDOG, 8'h83);
      end
      rdm(`OFS_FLAGS, 8'h80, 8'h00);
      wr(`OFS_IRQCFG, 8'h88);
      hiMode = 1'b1;
      cyc(5 * D32);
      pinChk(1'b1);
      wr(`OFS_WDOG, 8'h00);
      rdm(`OFS_FLAGS, 8'h80, 8'h80);
      cyc(3);
      pinChk(1'b0);
      wr(`OFS_WDOG, 8'h45);
      wr(`OFS_WDOG, 8'h0A);
      rdm(`OFS_WDOG, 8'hFF, 8'h05);
      wr(`OFS_WDOG, 8'h00);
      rdm(`OFS_WDOG, 8'hFF, 8'h00);
      u_host.acc(1'b0, `OFS_FLAGS, 8'h00, rd);
      cyc(6 * D32);
      rdm(`OFS_FLAGS, 8'h80, 8'h00);
      $display("test watchdog done");
      // square wave: count pin changes over 16 cycles
      wr(`OFS_FLAGS, 8'h04);
      rdm(`OFS_FLAGS, 8'h04, 8'h04);
      cnt = 0;
      p = intPin;
      repeat (16) begin
         cyc(1);
         if (intPin !== p) cnt++;
         p = intPin;
      end
      chk(8'(cnt >= 6), 8'h01);
      wr(`OFS_FLAGS, 8'h00);
      cyc(4);
      cnt = 0;
      p = intPin;
      repeat (16) begin
         cyc(1);
         if (intPin !== p) cnt++;
         p = intPin;
      end
      chk(8'(cnt), 8'h00);
      $display("test calibration done");
      wr(`OFS_FLAGS, 8'h02);
      chk({7'h00, clockHold}, 8'h01);
      wr(`OFS_FLAGS, 8'h00);
      cnt = 0;
      repeat (3) begin
         if (clockLoad === 1'b1) cnt++;
         cyc(1);
      end
      chk(8'(cnt), 8'h01);
      chk({7'h00, clockHold}, 8'h00);
      $display("test hold done");
      crystalFail = 1'b1;
      cyc(1);
      crystalFail = 1'b0;
      rdm(`OFS_FLAGS, 8'h10, 8'h10);
      rdm(`OFS_FLAGS, 8'h10, 8'h10);
      // a second power-up keeps crystal fail and clears the rest
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      rdm(`OFS_FLAGS, 8'hFF, 8'h10);
      wr(`OFS_FLAGS, 8'h00);
      rdm(`OFS_FLAGS, 8'h10, 8'h00);
      $display("test crystal done");
      finish_test();
   end
endmodule
